// file: hw/maint_cfg.svh
// Offsets, field positions, reset values and codes for the maintenance bridge.
// Assumes inclusion by the bridge package and modules only.
`ifndef MAINT_CFG_SVH
`define MAINT_CFG_SVH

// ----------------------------------------------------------------------------
// Local register offsets (24-bit configuration space)
// ----------------------------------------------------------------------------
`define BASE_DEVID_OFFSET 24'h000060
`define REQ_INFO_OFFSET 24'h000100

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BASE_DEVID_RESET 32'h00000000
`define REQ_INFO_RESET 32'h00000000

// ----------------------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------------------
`define HOP_MSB 31
`define HOP_LSB 24
`define OFF_MSB 23
`define WORD_LSB 2
`define HOP_LOCAL 8'h00
`define HOP_STEP 8'h01

// ----------------------------------------------------------------------------
// Request information register fields
// ----------------------------------------------------------------------------
`define TID_W 8
`define INFO_TID_MSB 7
`define INFO_TID_LSB 0
`define INFO_CRF_BIT 8
`define INFO_PRIO_MSB 10
`define INFO_PRIO_LSB 9
`define INFO_DEST_MSB 31
`define INFO_DEST_LSB 16
`define TID_STEP 8'h01

// ----------------------------------------------------------------------------
// Device ID, sizes and response codes
// ----------------------------------------------------------------------------
`define DEVID_MSB 15
`define DEVID_LSB 0
`define WORD_STRB 4'hF
`define WORD_BYTES 4'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: hw/maint_pkg.sv
// Types shared by the maintenance bridge and its helpers.
// Assumes the constants header is on the include path.
`include "maint_cfg.svh"

package maint_pkg;

	// ------------------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_CFG, S_REMOTE, S_REMOTE_WAIT, S_RESP} chan_state_e;
	typedef enum logic [2:0] {PK_NREAD, PK_NWRITE, PK_NWRITE_R, PK_SWRITE, PK_OTHER} pkt_kind_e;

	// ------------------------------------------------------------------------
	// Link-side carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic is_write;
		logic [`TID_W-1:0] tid;
		logic [15:0] src_id;
		logic [15:0] dest_id;
		logic [1:0] prio;
		logic crf;
		logic [7:0] hop;
		logic [23:0] offset;
		logic [31:0] data;
	} maint_req_s;

	typedef struct packed {
		logic is_write;
		logic [`TID_W-1:0] tid;
		logic error;
		logic [31:0] data;
	} maint_rsp_s;

	typedef struct packed {
		pkt_kind_e kind;
		logic [1:0] xamsbs;
		logic [7:0] addr_top;
		logic [3:0] size_bytes;
	} inb_pkt_s;

	typedef struct packed {
		logic hit;
		logic error;
	} window_verdict_s;

	// ------------------------------------------------------------------------
	// Module state
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic valid;
		window_verdict_s verdict;
	} window_state_s;

	typedef struct packed {
		logic busy;
		logic [`TID_W-1:0] tid;
	} tracker_state_s;

	typedef struct packed {
		chan_state_e wst;
		chan_state_e rst;
		logic aw_got;
		logic w_got;
		logic cfg_aw_done;
		logic cfg_w_done;
		logic cfg_ar_done;
		logic [31:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [31:0] raddr;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] base_devid;
		logic [31:0] req_info;
		logic req_valid;
		maint_req_s req;
	} bridge_state_s;

endpackage : maint_pkg

// file: hw/tid_tracker.sv
// Holds the transaction ID of one outstanding remote request.
// Assumes responses arrive already filtered by kind (read or write).
`timescale 1ns/1ns
`include "maint_cfg.svh"

module tid_tracker (
	// Clock and reset
	input logic i_core_clk,
	input logic i_rst_n,
	// Control
	input logic i_cancel,
	input logic i_issue,
	input logic [`TID_W-1:0] i_issue_tid,
	// Response watch
	input logic i_rsp_valid,
	input logic [`TID_W-1:0] i_rsp_tid,
	// Status
	output logic o_busy,
	output logic o_match
);
	import maint_pkg::*;

	tracker_state_s st;
	tracker_state_s next_st;

	// Foreign IDs never match, so they fall away silently
	assign o_match = st.busy & i_rsp_valid & (i_rsp_tid == st.tid); // [RULE16] [RULE19]
	assign o_busy = st.busy;

	always_comb begin
		next_st = st;
		if (i_issue) begin
			next_st.busy = 1'b1;
			next_st.tid = i_issue_tid;
		end
		if (o_match) begin
			next_st.busy = 1'b0;
		end
		if (i_cancel) begin
			next_st = '0; // [RULE20]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	a_cancel_clears: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_cancel |=> !o_busy) else $error("tracker busy after cancel"); // [RULE20]

endmodule : tid_tracker

// file: hw/config_window_check.sv
// Classifies inbound I/O packets against the local configuration window.
// Assumes the window value comes from the configuration register space.
`timescale 1ns/1ns
`include "maint_cfg.svh"

module config_window_check (
	// Clock and reset
	input logic i_core_clk,
	input logic i_rst_n,
	// Inbound packet header
	input logic i_inb_valid,
	input maint_pkg::inb_pkt_s i_inb,
	input logic [9:0] i_local_config_base_window,
	// Verdict
	output logic o_verdict_valid,
	output maint_pkg::window_verdict_s o_verdict
);
	import maint_pkg::*;

	window_state_s st;
	window_state_s next_st;
	logic match;
	logic supported;

	always_comb begin
		match = ({i_inb.xamsbs, i_inb.addr_top} == i_local_config_base_window); // [RULE17]
		supported = (i_inb.kind == PK_NREAD) || (i_inb.kind == PK_NWRITE) ||
			(i_inb.kind == PK_NWRITE_R);
		next_st.valid = i_inb_valid;
		next_st.verdict.hit = i_inb_valid & match & (i_inb.kind != PK_OTHER); // [RULE17]
		// Streaming writes hit but are still refused
		// Unlisted kinds are not hits, yet a window match still earns an error
		next_st.verdict.error = i_inb_valid & match &
			(!supported || (i_inb.size_bytes != `WORD_BYTES)); // [RULE1] [RULE3]
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_verdict_valid = st.valid;
	assign o_verdict = st.verdict;

	a_window_type_err: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_inb_valid && match && !supported) |=> o_verdict.error)
		else $error("unsupported window hit not errored"); // [RULE1]
	a_window_size_err: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_inb_valid && match && (i_inb.size_bytes != `WORD_BYTES)) |=> o_verdict.error)
		else $error("odd-size window hit not errored"); // [RULE3]

endmodule : config_window_check

// file: hw/maintenance_request_bridge.sv
// Maintenance port bridge: routes word accesses locally or to a remote device.
// Assumes the user master, fabric and link share i_core_clk.
//
// Overview of operation
// [RULE1] Unsupported window hit types get error response
// [RULE2] Errored writes never reach the register
// [RULE3] Non-word sizes get error response
// [RULE4] One read, one write outstanding at most
// [RULE5] Master zeroes upper byte for local access
// [RULE6] Offset on address [23:0], hop above
// [RULE7] Lowest two address bits are ignored
// [RULE8] Master drives address, valid and data
// [RULE9] Local access forwarded when fabric free
// [RULE10] Fabric completion returned on response channel
// [RULE11] Nonzero upper byte goes remote, hop minus one
// [RULE12] Master uses hop 0xFF for endpoints
// [RULE13] Source ID from base device ID
// [RULE14] Priority, CRF, destination from info register
// [RULE15] TID starts zero, increments, readable, writable
// [RULE16] Matching response returns status and data
// [RULE17] Window match on xamsbs and top byte
// [RULE18] Remote window accesses use I/O ports
// [RULE19] Mismatched response IDs silently dropped
// [RULE20] Port cancel drops requests and IDs
// [RULE21] Write waits for address and data
// [RULE22] Errors answer SLVERR, success OKAY
`timescale 1ns/1ns
`include "maint_cfg.svh"

module maintenance_request_bridge (
	// Clock and reset
	input logic i_core_clk,
	input logic i_rst_n,
	input logic i_maint_cancel,
	// Maintenance port write channels
	input logic i_maint_awvalid,
	output logic o_maint_awready,
	input logic [31:0] i_maint_awaddr,
	input logic i_maint_wvalid,
	output logic o_maint_wready,
	input logic [31:0] i_maint_wdata,
	input logic [3:0] i_maint_wstrb,
	output logic o_maint_bvalid,
	input logic i_maint_bready,
	output logic [1:0] o_maint_bresp,
	// Maintenance port read channels
	input logic i_maint_arvalid,
	output logic o_maint_arready,
	input logic [31:0] i_maint_araddr,
	output logic o_maint_rvalid,
	input logic i_maint_rready,
	output logic [31:0] o_maint_rdata,
	output logic [1:0] o_maint_rresp,
	// Configuration fabric master
	output logic o_cfg_awvalid,
	input logic i_cfg_awready,
	output logic [31:0] o_cfg_awaddr,
	output logic o_cfg_wvalid,
	input logic i_cfg_wready,
	output logic [31:0] o_cfg_wdata,
	output logic [3:0] o_cfg_wstrb,
	input logic i_cfg_bvalid,
	output logic o_cfg_bready,
	input logic [1:0] i_cfg_bresp,
	output logic o_cfg_arvalid,
	input logic i_cfg_arready,
	output logic [31:0] o_cfg_araddr,
	input logic i_cfg_rvalid,
	output logic o_cfg_rready,
	input logic [31:0] i_cfg_rdata,
	input logic [1:0] i_cfg_rresp,
	// Remote request and response
	output logic o_req_valid,
	input logic i_req_ready,
	output maint_pkg::maint_req_s o_req,
	input logic i_rsp_valid,
	input maint_pkg::maint_rsp_s i_rsp,
	// Inbound window check
	input logic i_inb_valid,
	input maint_pkg::inb_pkt_s i_inb,
	input logic [9:0] i_local_config_base_window,
	output logic o_verdict_valid,
	output maint_pkg::window_verdict_s o_verdict,
	// Device identity
	output logic [15:0] o_deviceid
);
	import maint_pkg::*;

	bridge_state_s st;
	bridge_state_s next_st;
	logic wr_issue;
	logic rd_issue;
	logic wr_match;
	logic rd_match;

	// ------------------------------------------------------------------------
	// Address helpers
	// ------------------------------------------------------------------------
	function automatic logic [23:0] off_of(input logic [31:0] addr);
		off_of = {addr[`OFF_MSB:`WORD_LSB], 2'h0}; // [RULE6] [RULE7]
	endfunction : off_of

	function automatic logic [7:0] hop_of(input logic [31:0] addr);
		hop_of = addr[`HOP_MSB:`HOP_LSB]; // [RULE6]
	endfunction : hop_of

	function automatic maint_req_s build_req(input logic wr, input logic [31:0] addr,
		input logic [31:0] data, input logic [31:0] info, input logic [31:0] devid);
		build_req.is_write = wr;
		build_req.tid = info[`INFO_TID_MSB:`INFO_TID_LSB]; // [RULE15]
		build_req.src_id = devid[`DEVID_MSB:`DEVID_LSB]; // [RULE13]
		build_req.dest_id = info[`INFO_DEST_MSB:`INFO_DEST_LSB]; // [RULE14]
		build_req.prio = info[`INFO_PRIO_MSB:`INFO_PRIO_LSB]; // [RULE14]
		build_req.crf = info[`INFO_CRF_BIT]; // [RULE14]
		build_req.hop = hop_of(addr) - `HOP_STEP; // [RULE11]
		build_req.offset = off_of(addr);
		build_req.data = data;
	endfunction : build_req

	// ------------------------------------------------------------------------
	// Channel sequencing
	// ------------------------------------------------------------------------
	always_comb begin
		next_st = st;
		wr_issue = 1'b0;
		rd_issue = 1'b0;
		case (st.wst)
			S_IDLE: begin
				// Address and data may arrive in either order
				if (i_maint_awvalid && !st.aw_got) begin // [RULE21]
					next_st.aw_got = 1'b1;
					next_st.waddr = i_maint_awaddr;
				end
				if (i_maint_wvalid && !st.w_got) begin // [RULE21]
					next_st.w_got = 1'b1;
					next_st.wdata = i_maint_wdata;
					next_st.wstrb = i_maint_wstrb;
				end
				if (st.aw_got && st.w_got) begin
					next_st.aw_got = 1'b0;
					next_st.w_got = 1'b0;
					if (st.wstrb != `WORD_STRB) begin
						next_st.bresp = `RESP_SLVERR; // [RULE2] [RULE3] [RULE22]
						next_st.wst = S_RESP;
					end else if (hop_of(st.waddr) != `HOP_LOCAL) begin
						next_st.wst = S_REMOTE; // [RULE11]
					end else if (off_of(st.waddr) == `BASE_DEVID_OFFSET) begin
						next_st.base_devid = st.wdata;
						next_st.bresp = `RESP_OKAY;
						next_st.wst = S_RESP;
					end else if (off_of(st.waddr) == `REQ_INFO_OFFSET) begin
						next_st.req_info = st.wdata; // [RULE14] [RULE15]
						next_st.bresp = `RESP_OKAY;
						next_st.wst = S_RESP;
					end else begin
						next_st.cfg_aw_done = 1'b0;
						next_st.cfg_w_done = 1'b0;
						next_st.wst = S_CFG; // [RULE9]
					end
				end
			end
			S_CFG: begin
				if (o_cfg_awvalid && i_cfg_awready) begin
					next_st.cfg_aw_done = 1'b1;
				end
				if (o_cfg_wvalid && i_cfg_wready) begin
					next_st.cfg_w_done = 1'b1;
				end
				if (o_cfg_bready && i_cfg_bvalid) begin
					next_st.bresp = (i_cfg_bresp == `RESP_OKAY) ? `RESP_OKAY : `RESP_SLVERR; // [RULE10]
					next_st.wst = S_RESP;
				end
			end
			S_REMOTE_WAIT: begin
				if (wr_match) begin
					next_st.bresp = i_rsp.error ? `RESP_SLVERR : `RESP_OKAY; // [RULE16] [RULE22]
					next_st.wst = S_RESP;
				end
			end
			S_RESP: begin
				if (i_maint_bready) begin
					next_st.wst = S_IDLE; // [RULE4]
				end
			end
			default: begin
			end
		endcase
		case (st.rst)
			S_IDLE: begin
				if (i_maint_arvalid) begin
					next_st.raddr = i_maint_araddr;
					if (hop_of(i_maint_araddr) != `HOP_LOCAL) begin
						next_st.rst = S_REMOTE; // [RULE11]
					end else if (off_of(i_maint_araddr) == `BASE_DEVID_OFFSET) begin
						next_st.rdata = st.base_devid;
						next_st.rresp = `RESP_OKAY;
						next_st.rst = S_RESP;
					end else if (off_of(i_maint_araddr) == `REQ_INFO_OFFSET) begin
						next_st.rdata = st.req_info; // [RULE15]
						next_st.rresp = `RESP_OKAY;
						next_st.rst = S_RESP;
					end else begin
						next_st.cfg_ar_done = 1'b0;
						next_st.rst = S_CFG; // [RULE9]
					end
				end
			end
			S_CFG: begin
				if (o_cfg_arvalid && i_cfg_arready) begin
					next_st.cfg_ar_done = 1'b1;
				end
				if (o_cfg_rready && i_cfg_rvalid) begin
					next_st.rdata = i_cfg_rdata; // [RULE10]
					next_st.rresp = (i_cfg_rresp == `RESP_OKAY) ? `RESP_OKAY : `RESP_SLVERR;
					next_st.rst = S_RESP;
				end
			end
			S_REMOTE_WAIT: begin
				if (rd_match) begin
					next_st.rdata = i_rsp.data; // [RULE16]
					next_st.rresp = i_rsp.error ? `RESP_SLVERR : `RESP_OKAY; // [RULE22]
					next_st.rst = S_RESP;
				end
			end
			S_RESP: begin
				if (i_maint_rready) begin
					next_st.rst = S_IDLE; // [RULE4]
				end
			end
			default: begin
			end
		endcase
		// One request slot on the link; writes win ties
		if (!st.req_valid) begin
			if (st.wst == S_REMOTE) begin
				next_st.req = build_req(1'b1, st.waddr, st.wdata, st.req_info, st.base_devid);
				next_st.req_valid = 1'b1;
			end else if (st.rst == S_REMOTE) begin
				next_st.req = build_req(1'b0, st.raddr, 32'h00000000, st.req_info, st.base_devid);
				next_st.req_valid = 1'b1;
			end
		end else if (i_req_ready) begin
			next_st.req_valid = 1'b0;
			next_st.req_info[`INFO_TID_MSB:`INFO_TID_LSB] = st.req.tid + `TID_STEP; // [RULE15]
			if (st.req.is_write) begin
				wr_issue = 1'b1;
				next_st.wst = S_REMOTE_WAIT;
			end else begin
				rd_issue = 1'b1;
				next_st.rst = S_REMOTE_WAIT;
			end
		end
		// Cancel abandons everything in flight; the port should be quiet meanwhile
		if (i_maint_cancel) begin
			next_st.wst = S_IDLE; // [RULE20]
			next_st.rst = S_IDLE;
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.req_valid = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
			st.base_devid <= `BASE_DEVID_RESET;
			st.req_info <= `REQ_INFO_RESET; // [RULE15]
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------------
	// Helpers and outputs
	// ------------------------------------------------------------------------
	tid_tracker u_wr_track (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_cancel(i_maint_cancel),
		.i_issue(wr_issue),
		.i_issue_tid(st.req.tid),
		.i_rsp_valid(i_rsp_valid & i_rsp.is_write),
		.i_rsp_tid(i_rsp.tid),
		.o_busy(),
		.o_match(wr_match)
	);

	tid_tracker u_rd_track (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_cancel(i_maint_cancel),
		.i_issue(rd_issue),
		.i_issue_tid(st.req.tid),
		.i_rsp_valid(i_rsp_valid & !i_rsp.is_write),
		.i_rsp_tid(i_rsp.tid),
		.o_busy(),
		.o_match(rd_match)
	);

	config_window_check u_window (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_inb_valid(i_inb_valid),
		.i_inb(i_inb),
		.i_local_config_base_window(i_local_config_base_window),
		.o_verdict_valid(o_verdict_valid),
		.o_verdict(o_verdict)
	);

	assign o_maint_awready = (st.wst == S_IDLE) & !st.aw_got; // [RULE4] [RULE21]
	assign o_maint_wready = (st.wst == S_IDLE) & !st.w_got; // [RULE4] [RULE21]
	assign o_maint_bvalid = (st.wst == S_RESP);
	assign o_maint_bresp = st.bresp;
	assign o_maint_arready = (st.rst == S_IDLE); // [RULE4]
	assign o_maint_rvalid = (st.rst == S_RESP);
	assign o_maint_rdata = st.rdata;
	assign o_maint_rresp = st.rresp;
	assign o_cfg_awvalid = (st.wst == S_CFG) & !st.cfg_aw_done; // [RULE9]
	assign o_cfg_awaddr = {`HOP_LOCAL, off_of(st.waddr)}; // [RULE7]
	assign o_cfg_wvalid = (st.wst == S_CFG) & !st.cfg_w_done;
	assign o_cfg_wdata = st.wdata;
	assign o_cfg_wstrb = `WORD_STRB;
	assign o_cfg_bready = (st.wst == S_CFG) & st.cfg_aw_done & st.cfg_w_done;
	assign o_cfg_arvalid = (st.rst == S_CFG) & !st.cfg_ar_done; // [RULE9]
	assign o_cfg_araddr = {`HOP_LOCAL, off_of(st.raddr)}; // [RULE7]
	assign o_cfg_rready = (st.rst == S_CFG) & st.cfg_ar_done;
	assign o_req_valid = st.req_valid;
	assign o_req = st.req;
	assign o_deviceid = st.base_devid[`DEVID_MSB:`DEVID_LSB]; // [RULE13]

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	a_hop_minus_one: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_req_valid && o_req.is_write) |-> (o_req.hop == hop_of(st.waddr) - `HOP_STEP))
		else $error("remote hop count wrong"); // [RULE11]
	a_source_id: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_req_valid |-> (o_req.src_id == o_deviceid))
		else $error("source id differs from device id"); // [RULE13]
	a_tid_advance: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_req_valid && i_req_ready) |=>
		(st.req_info[`INFO_TID_MSB:`INFO_TID_LSB] == $past(o_req.tid) + `TID_STEP))
		else $error("tid did not advance"); // [RULE15]
	a_strobe_error: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || i_maint_cancel)
		((st.wst == S_IDLE) && st.aw_got && st.w_got && (st.wstrb != `WORD_STRB)) |=>
		(o_maint_bvalid && (o_maint_bresp == `RESP_SLVERR)))
		else $error("partial write not errored"); // [RULE3]
	a_err_no_fabric: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_cfg_awvalid |-> (st.wstrb == `WORD_STRB))
		else $error("errored write reached fabric"); // [RULE2]
	a_one_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_maint_bvalid || o_cfg_awvalid || (st.wst == S_REMOTE_WAIT)) |->
		(!o_maint_awready && !o_maint_wready))
		else $error("second write accepted"); // [RULE4]
	a_one_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_maint_rvalid || (st.rst == S_REMOTE_WAIT)) |-> !o_maint_arready)
		else $error("second read accepted"); // [RULE4]
	a_drop_mismatch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || i_maint_cancel)
		((st.wst == S_REMOTE_WAIT) && i_rsp_valid && i_rsp.is_write && !wr_match) |=>
		(st.wst == S_REMOTE_WAIT))
		else $error("mismatched response consumed"); // [RULE19]
	a_cancel_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_maint_cancel |=> ((st.wst == S_IDLE) && (st.rst == S_IDLE) && !o_req_valid))
		else $error("cancel left work in flight"); // [RULE20]
	a_word_offset: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_cfg_arvalid |-> (o_cfg_araddr[1:0] == 2'h0))
		else $error("fabric address not word aligned"); // [RULE7]

	c_remote_write: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st.wst == S_REMOTE_WAIT) ##[1:20] o_maint_bvalid);
	c_local_read: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_cfg_rready && i_cfg_rvalid) ##1 o_maint_rvalid);
	c_strobe_error: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_maint_bvalid && (o_maint_bresp == `RESP_SLVERR));
	c_both_remote: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(st.wst == S_REMOTE_WAIT) && (st.rst == S_REMOTE_WAIT));

endmodule : maintenance_request_bridge

// file: verif/far_side_model.sv
// Far-side model: configuration fabric slave and remote link responder.
// Assumes one clock shared with the bridge; fabric readies always high.
`timescale 1ns/1ns

module far_side_model (
	// Clock, reset, fault control
	input wire logic i_core_clk, i_rst_n, i_bad,
	// Fabric slave
	input wire logic i_awv, i_wv, i_br, i_arv, i_rr,
	input wire logic [31:0] i_awaddr, i_wdata, i_araddr,
	output logic o_rdy, o_bv, o_rv,
	output logic [31:0] o_rdata,
	// Remote link
	input wire logic i_req_valid,
	input wire maint_pkg::maint_req_s i_req,
	output maint_pkg::maint_rsp_s o_rsp,
	output logic o_rsp_valid
);
	import maint_pkg::*;
	logic [31:0] mem [4];
	logic ga, gw, w;
	logic [1:0] wa;
	logic [31:0] wd, f;
	logic [3:0] c;
	logic [7:0] t;
	assign o_rdy = 1'b1;
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{ga, gw, o_bv, o_rv, o_rsp_valid, c} <= '0;
			o_rdata <= '0;
			o_rsp <= '0;
		end else begin
			// Address and data may land in either order
			if (i_awv) begin
				ga <= 1'b1;
				wa <= i_awaddr[3:2];
			end
			if (i_wv) begin
				gw <= 1'b1;
				wd <= i_wdata;
			end
			if (ga && gw && !o_bv) begin
				mem[wa] <= wd;
				o_bv <= 1'b1;
				ga <= 1'b0;
				gw <= 1'b0;
			end else if (o_bv && i_br) begin
				o_bv <= 1'b0;
			end
			// Idle data toggles so stale values never look valid
			if (!o_rv) o_rdata <= ~o_rdata;
			if (i_arv && !o_rv) begin
				o_rv <= 1'b1;
				o_rdata <= mem[i_araddr[3:2]];
			end else if (o_rv && i_rr) begin
				o_rv <= 1'b0;
			end
			o_rsp_valid <= 1'b0;
			o_rsp <= ~o_rsp;
			if (c != 4'h0) c <= c - 4'h1;
			if (i_req_valid) begin
				c <= 4'h6;
				t <= i_req.tid;
				w <= i_req.is_write;
				f <= {8'hA5, i_req.offset};
			end
			if (c == 4'h4 && i_bad) begin
				o_rsp_valid <= 1'b1;
				o_rsp <= {w, t ^ 8'h01, 1'b1, f};
			end
			if (c == 4'h1) begin
				o_rsp_valid <= 1'b1;
				o_rsp <= {w, t, 1'b0, f};
			end
		end
	end
endmodule : far_side_model

// file: verif/tb_top.sv
// Self-checking bench for the maintenance bridge.
// Assumes the far-side model stands in for fabric and link.
`timescale 1ns/1ns

module tb_top;
	import maint_pkg::*;
	logic clk, rst_n, awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd, bad, cancel;
	logic cawv, cwv, cbv, cbr, carv, crv, crr, crdy, qv, sv, iv, vv;
	logic [31:0] awa, wd, ara, rdata, cawa, cwd, cara, crd, d;
	logic [1:0] bresp, rresp, r;
	logic [3:0] ws;
	logic [15:0] devid;
	maint_req_s q, lq;
	maint_rsp_s s;
	inb_pkt_s inb;
	window_verdict_s vd;
	int miscompares, checked, k;
	maintenance_request_bridge u_dut (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_maint_cancel(cancel),
		.i_maint_awvalid(awv), .o_maint_awready(awr), .i_maint_awaddr(awa),
		.i_maint_wvalid(wv), .o_maint_wready(wrd), .i_maint_wdata(wd), .i_maint_wstrb(ws),
		.o_maint_bvalid(bv), .i_maint_bready(brd), .o_maint_bresp(bresp),
		.i_maint_arvalid(arv), .o_maint_arready(arr), .i_maint_araddr(ara),
		.o_maint_rvalid(rv), .i_maint_rready(rrd), .o_maint_rdata(rdata), .o_maint_rresp(rresp),
		.o_cfg_awvalid(cawv), .i_cfg_awready(crdy), .o_cfg_awaddr(cawa),
		.o_cfg_wvalid(cwv), .i_cfg_wready(crdy), .o_cfg_wdata(cwd), .o_cfg_wstrb(),
		.i_cfg_bvalid(cbv), .o_cfg_bready(cbr), .i_cfg_bresp({bad, 1'b0}),
		.o_cfg_arvalid(carv), .i_cfg_arready(crdy), .o_cfg_araddr(cara),
		.i_cfg_rvalid(crv), .o_cfg_rready(crr), .i_cfg_rdata(crd), .i_cfg_rresp(2'h0),
		.o_req_valid(qv), .i_req_ready(crdy), .o_req(q), .i_rsp_valid(sv), .i_rsp(s),
		.i_inb_valid(iv), .i_inb(inb), .i_local_config_base_window(10'h180),
		.o_verdict_valid(vv), .o_verdict(vd), .o_deviceid(devid));
	far_side_model u_far (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_bad(bad), .i_awv(cawv), .i_wv(cwv),
		.i_br(cbr), .i_arv(carv), .i_rr(crr), .i_awaddr(cawa), .i_wdata(cwd),
		.i_araddr(cara), .o_rdy(crdy), .o_bv(cbv), .o_rv(crv), .o_rdata(crd),
		.i_req_valid(qv), .i_req(q), .o_rsp(s), .o_rsp_valid(sv));
	always @(posedge clk) if (qv && crdy) lq <= q;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task give_verdict;
		if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task chk(input logic [127:0] g, e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task wait_bound(input int n);
		if (n >= 99) begin
			miscompares++;
			give_verdict;
		end
	endtask : wait_bound
	// Requests held from a falling edge until the ready seen before the rising edge
	task wr(input logic [31:0] a, v, input logic [3:0] st, output logic [1:0] o);
		logic ga, gw;
		int n;
		awa = a;
		wd = v;
		ws = st;
		awv = 1'b1;
		wv = 1'b1;
		for (n = 0; n < 99 && (awv || wv); n++) begin
			ga = awr;
			gw = wrd;
			@(negedge clk);
			if (ga) awv = 1'b0;
			if (gw) wv = 1'b0;
		end
		wait_bound(n);
		brd = 1'b1;
		for (n = 0; n < 99 && !bv; n++) @(negedge clk);
		wait_bound(n);
		o = bresp;
		@(negedge clk);
		brd = 1'b0;
	endtask : wr
	task rd(input logic [31:0] a, output logic [31:0] o);
		int n;
		ara = a;
		arv = 1'b1;
		for (n = 0; n < 99 && !arr; n++) @(negedge clk);
		wait_bound(n);
		@(negedge clk);
		arv = 1'b0;
		rrd = 1'b1;
		for (n = 0; n < 99 && !rv; n++) @(negedge clk);
		wait_bound(n);
		o = rdata;
		@(negedge clk);
		rrd = 1'b0;
	endtask : rd
	initial begin
		{rst_n, awv, wv, brd, arv, rrd, bad, cancel, iv, awa, wd, ara, ws} = '0;
		inb = '0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		rd(32'h00000060, d);
		chk(d, 32'h0);
		rd(32'h00000100, d);
		chk(d, 32'h0);
		wr(32'h00000063, 32'h00001234, 4'hF, r);
		chk(r, 2'h0);
		wr(32'h00000060, 32'h00005678, 4'h3, r);
		chk(r, 2'h2);
		rd(32'h00000061, d);
		chk(d, 32'h1234);
		chk(devid, 16'h1234);
		wr(32'h00000208, 32'hCAFE0001, 4'hF, r);
		chk(r, 2'h0);
		rd(32'h00000208, d);
		chk(d, 32'hCAFE0001);
		wr(32'h00000100, 32'hBEEF0603, 4'hF, r);
		bad = 1'b1;
		wr(32'h0000020C, 32'h00000000, 4'hF, r);
		chk(r, 2'h2);
		wr(32'h05000043, 32'h11223344, 4'hF, r);
		chk(r, 2'h0);
		chk(lq, {1'b1, 8'h03, 16'h1234, 16'hBEEF, 3'h6, 8'h04, 24'h40, 32'h11223344});
		bad = 1'b0;
		rd(32'hFF000010, d);
		chk(d, 32'hA5000010);
		chk(lq, {1'b0, 8'h04, 16'h1234, 16'hBEEF, 3'h6, 8'hFE, 24'h10, 32'h0});
		rd(32'h00000100, d);
		chk(d, 32'hBEEF0605);
		// Remote read cancelled in flight; its late answer must fall away
		ara = 32'h01000020;
		arv = 1'b1;
		@(negedge clk);
		arv = 1'b0;
		repeat (3) @(negedge clk);
		cancel = 1'b1;
		@(negedge clk);
		cancel = 1'b0;
		chk(arr, 1'b1);
		repeat (6) @(negedge clk);
		chk(rv, 1'b0);
		rd(32'h00000100, d);
		chk(d, 32'hBEEF0606);
		// Every packet kind, one short size, one window miss
		for (k = 0; k < 7; k++) begin
			inb = {k < 5 ? pkt_kind_e'(k) : PK_NWRITE, 2'h1, k == 6 ? 8'h81 : 8'h80,
				k == 5 ? 4'h2 : 4'h4};
			iv = 1'b1;
			@(negedge clk);
			iv = 1'b0;
			chk(vv, 1'b1);
			chk(vd, {k != 4 && k != 6, k >= 3 && k <= 5});
		end
		give_verdict;
	end
endmodule : tb_top
